// File: src/cell_consts.svh
/*
  Offsets, field positions, reset values and depths of the logic cell.
  Assumes it is included by bare name by the cell design file.
*/
`ifndef CELL_CONSTS_SVH
`define CELL_CONSTS_SVH
`define ADDR_ACC0 5'h00
`define ADDR_ACC1 5'h01
`define ADDR_OPR0 5'h02
`define ADDR_OPR1 5'h03
`define ADDR_QUEUE0 5'h04
`define ADDR_QUEUE1 5'h05
`define ADDR_OR_MASK 5'h06
`define ADDR_CTL 5'h07
`define ADDR_CMP_MASK 5'h08
`define ADDR_POLY 5'h09
`define ADDR_STATUS 5'h0A
`define ADDR_OSEL_LO 5'h0B
`define ADDR_OSEL_HI 5'h0C
`define CFG_PAGE 2'h2
`define CTL_MSB 2:0
`define CTL_Q0_OUT 3
`define CTL_Q1_OUT 4
`define CTL_PAIR 5
`define CTL_CRC 6
`define CTL_CHAIN 7
`define CTL_RST 8'h07
`define OR_MASK_RST 8'h00
`define CMP_MASK_RST 16'hFFFF
`define POLY_RST 8'h00
`define OSEL_RST 24'h000000
`define CFG_RST 16'h0000
`define REG_RST 8'h00
`define QUEUE_DEPTH 4
`define PO_DEPTH 8
`define DP_ADDR 2:0
`define DP_SIN_L 3
`define DP_CIN 4
`define DP_SIN_R 5
`endif

// File: src/cell_pkg.sv
/*
  Types of the logic cell: configuration word, routing chain bundles,
  logic array setup and the register bus request.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cell_pkg;
  typedef enum logic [2:0] {
    F_INC, F_DEC, F_ADD, F_SUB, F_AND, F_OR, F_XOR, F_PASS
  } alu_func_t;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} shift_op_t;
  typedef enum logic [1:0] {SRC_ACC0, SRC_ACC1, SRC_OPR0, SRC_OPR1} src_sel_t;
  typedef enum logic [1:0] {WR_HOLD, WR_ALU, WR_QUEUE, WR_SRCB} acc_wr_t;
  typedef struct packed {
    logic po_push;
    logic q_strobe;
    logic cin_route;
    acc_wr_t a1_sel;
    acc_wr_t a0_sel;
    shift_op_t shift;
    src_sel_t srcb;
    src_sel_t srca;
    alu_func_t func;
  } cfg_word_t;
  typedef struct packed {
    logic carry;
    logic shl;
    logic eq;
  } chain_up_t;
  typedef struct packed {
    logic shr;
    logic fb;
  } chain_down_t;
  typedef struct packed {
    logic [7:0][11:0] pt_true;
    logic [7:0][11:0] pt_comp;
    logic [3:0][7:0] or_sel;
    logic [3:0] reg_out;
  } pld_cfg_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } bus_req_t;
endpackage

// File: src/logic_cell.sv
/*
  Configurable logic cell: two sum-of-products arrays, an 8-bit datapath
  with two queues, and an 8-deep parallel output buffer.
  Assumes routed inputs, chain inputs and the bus are on sys_clk.
*/
`include "cell_consts.svh"
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // depth must be a power of two: pointers wrap by overflow
  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

module logic_cell #(
  parameter int QDEPTH = `QUEUE_DEPTH,
  parameter int PODEPTH = `PO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cell_pkg::bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  input wire logic [5:0] dp_in,
  output logic [5:0] dp_out,
  input wire cell_pkg::chain_up_t up_in,
  input wire cell_pkg::chain_down_t down_in,
  output cell_pkg::chain_up_t up_out,
  output cell_pkg::chain_down_t down_out,
  input wire logic [1:0][11:0] pld_in,
  input wire cell_pkg::pld_cfg_t [1:0] pld_cfg,
  output logic [1:0][3:0] pld_out,
  output logic [7:0] po_data,
  output logic po_valid,
  input wire logic po_ready
);
  import cell_pkg::*;

  function automatic logic [7:0] pick(input src_sel_t s, input logic [1:0][7:0] a,
                                      input logic [1:0][7:0] d);
    unique case (s)
      SRC_ACC0: return a[0];
      SRC_ACC1: return a[1];
      SRC_OPR0: return d[0];
      SRC_OPR1: return d[1];
    endcase
  endfunction

  // logic arrays
  logic [1:0][7:0] pterm;
  logic [1:0][3:0] sop;
  logic [1:0][3:0] pld_q;
  for (genvar p = 0; p < 2; p++) begin : g_pld
    for (genvar t = 0; t < 8; t++) begin : g_pt
      wire [11:0] tm = pld_cfg[p].pt_true[t];
      wire [11:0] cm = pld_cfg[p].pt_comp[t];
      // an empty term reads low so that an unused term never forces a sum high
      assign pterm[p][t] = (|(tm | cm)) & (&((pld_in[p] | ~tm) & (~pld_in[p] | ~cm)));
    end
    for (genvar o = 0; o < 4; o++) begin : g_out
      assign sop[p][o] = |(pterm[p] & pld_cfg[p].or_sel[o]);
      assign pld_out[p][o] = pld_cfg[p].reg_out[o] ? pld_q[p][o] : sop[p][o];
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pld_q <= '0;
    end else begin
      pld_q <= sop;
    end
  end

  // working and setup registers
  logic [1:0][7:0] acc;
  logic [1:0][7:0] opr;
  logic [1:0][7:0] next_acc;
  logic [1:0][7:0] next_opr;
  logic [15:0] cfg_ram [8];
  logic [7:0] or_mask;
  logic [7:0] ctl;
  logic [7:0] poly;
  logic [15:0] cmp_mask;
  logic [23:0] osel;
  cfg_word_t cfg;
  assign cfg = cfg_word_t'(cfg_ram[dp_in[`DP_ADDR]]);

  wire [2:0] msb = ctl[`CTL_MSB];
  wire chain = ctl[`CTL_CHAIN];
  wire crc_mode = ctl[`CTL_CRC];
  wire [1:0] q_out_dir = {ctl[`CTL_Q1_OUT], ctl[`CTL_Q0_OUT]};
  wire [7:0] wmask = 8'hFF >> (3'h7 - msb);
  wire [3:0] top = {1'b0, msb} + 4'h1;

  // operands and ALU
  wire [7:0] srca = pick(cfg.srca, acc, opr);
  wire [7:0] srcb = pick(cfg.srcb, acc, opr);
  wire cin = chain ? up_in.carry : dp_in[`DP_CIN];
  wire sin_l = chain ? up_in.shl : dp_in[`DP_SIN_L];
  wire sin_r = chain ? down_in.shr : dp_in[`DP_SIN_R];
  wire incdec = cfg.func == F_INC || cfg.func == F_DEC;
  wire ci = cfg.cin_route ? cin : incdec;
  wire [7:0] am = srca & wmask;
  wire [7:0] bm = incdec ? 8'h00 : (srcb & wmask);
  wire [8:0] sum9 = {1'b0, am} + {1'b0, bm} + {8'h00, ci};
  wire [8:0] dif9 = {1'b0, am} - {1'b0, bm} - {8'h00, ci};
  wire is_sub = cfg.func == F_DEC || cfg.func == F_SUB;
  wire is_arith = !cfg.func[2];
  logic [7:0] alu;
  always_comb begin
    unique case (cfg.func)
      F_INC, F_ADD: alu = sum9[7:0];
      F_DEC, F_SUB: alu = dif9[7:0];
      F_AND: alu = srca & srcb;
      F_OR: alu = srca | srcb;
      F_XOR: alu = srca ^ srcb;
      F_PASS: alu = srca;
    endcase
  end
  // carry and overflow are taken at the programmed top bit
  wire carry = is_arith & (is_sub ? dif9[top] : sum9[top]);
  wire sa = am[msb];
  wire sb = bm[msb];
  wire sr = alu[msb];
  wire ovf = is_arith & (is_sub ? (sa != sb) : (sa == sb)) & (sr != sa);

  // CRC/PRS step: feedback from the top cell travels down the chain
  wire fb = chain ? down_in.fb : (srca[msb] ^ sin_l);
  wire [7:0] crc = ({srca[6:0], chain & up_in.shl} ^ (fb ? poly : 8'h00)) & wmask;

  // shift, swap and mask stage
  logic [7:0] shifted;
  always_comb begin
    unique case (cfg.shift)
      SH_NONE: shifted = alu;
      SH_LEFT: shifted = {alu[6:0], sin_l} & wmask;
      SH_RIGHT: shifted = ((alu & wmask) >> 1) | ({7'h00, sin_r} << msb);
      SH_SWAP: shifted = {alu[3:0], alu[7:4]};
    endcase
  end
  wire [7:0] result = (crc_mode ? crc : shifted) | or_mask;
  assign up_out.carry = carry;
  assign up_out.shl = crc_mode ? srca[msb] : alu[msb];
  assign down_out.shr = alu[0];
  assign down_out.fb = fb;

  // compares and detectors
  wire pair = ctl[`CTL_PAIR];
  wire [7:0] c0a = acc[0] & cmp_mask[7:0];
  wire [7:0] c0b = (pair ? acc[1] : opr[0]) & cmp_mask[7:0];
  wire [7:0] c1a = acc[1] & cmp_mask[15:8];
  wire [7:0] c1b = (pair ? opr[0] : opr[1]) & cmp_mask[15:8];
  wire eq0 = (c0a == c0b) & (!chain | up_in.eq);
  assign up_out.eq = eq0;
  wire lt0 = c0a < c0b;
  wire eq1 = c1a == c1b;
  wire lt1 = c1a < c1b;
  wire [1:0] zero_det = {(acc[1] & wmask) == 8'h00, (acc[0] & wmask) == 8'h00};
  wire [1:0] ones_det = {(acc[1] & wmask) == wmask, (acc[0] & wmask) == wmask};

  // queues and output buffer
  logic [1:0] q_in_valid;
  logic [1:0] q_in_ready;
  logic [1:0] q_out_valid;
  logic [1:0] q_out_ready;
  logic [1:0][7:0] q_in_data;
  logic [1:0][7:0] q_head;
  logic po_in_ready;
  // a full output buffer stalls every datapath update rather than losing a word; bus writes still land
  wire stall = cfg.po_push & !po_in_ready;
  wire go = !stall;
  wire [15:0] cond = {po_valid, !q_in_ready[1], !q_out_valid[1], !q_in_ready[0],
                      !q_out_valid[0], down_out.shr, carry, ovf, ones_det, zero_det,
                      lt1, eq1, lt0, eq0};
  wire bus_q_wr0 = bus_req.wr && bus_req.addr == `ADDR_QUEUE0;
  wire bus_q_wr1 = bus_req.wr && bus_req.addr == `ADDR_QUEUE1;
  wire bus_q_rd0 = bus_req.rd && bus_req.addr == `ADDR_QUEUE0;
  wire bus_q_rd1 = bus_req.rd && bus_req.addr == `ADDR_QUEUE1;
  wire [1:0] bus_q_wr = {bus_q_wr1, bus_q_wr0};
  wire [1:0] bus_q_rd = {bus_q_rd1, bus_q_rd0};
  wire [1:0] a_wr = {bus_req.wr && bus_req.addr == `ADDR_ACC1,
                     bus_req.wr && bus_req.addr == `ADDR_ACC0};
  wire [1:0] d_wr = {bus_req.wr && bus_req.addr == `ADDR_OPR1,
                     bus_req.wr && bus_req.addr == `ADDR_OPR0};
  acc_wr_t [1:0] a_sel;
  assign a_sel[0] = cfg.a0_sel;
  assign a_sel[1] = cfg.a1_sel;

  for (genvar n = 0; n < 2; n++) begin : g_q
    wire from_q = go & !q_out_dir[n] & q_out_valid[n];
    wire take_a = from_q & (a_sel[n] == WR_QUEUE);
    wire take_d = from_q & cfg.q_strobe;
    // input buffer: bus fills, datapath drains; output buffer: the reverse
    assign q_in_valid[n] = q_out_dir[n] ? (go & cfg.q_strobe) : bus_q_wr[n];
    assign q_in_data[n] = q_out_dir[n] ? result : bus_req.wdata[7:0];
    assign q_out_ready[n] = q_out_dir[n] ? bus_q_rd[n] : (take_a | take_d);
    assign next_acc[n] = a_wr[n] ? bus_req.wdata[7:0] :
                         !go ? acc[n] :
                         a_sel[n] == WR_ALU ? result :
                         a_sel[n] == WR_SRCB ? srcb :
                         take_a ? q_head[n] : acc[n];
    assign next_opr[n] = d_wr[n] ? bus_req.wdata[7:0] : take_d ? q_head[n] : opr[n];
    byte_fifo #(.WIDTH(8), .DEPTH(QDEPTH)) u_queue (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(q_in_valid[n]),
      .in_ready(q_in_ready[n]),
      .in_data(q_in_data[n]),
      .out_valid(q_out_valid[n]),
      .out_ready(q_out_ready[n]),
      .out_data(q_head[n])
    );
  end

  byte_fifo #(.WIDTH(8), .DEPTH(PODEPTH)) u_po (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(cfg.po_push),
    .in_ready(po_in_ready),
    .in_data(result),
    .out_valid(po_valid),
    .out_ready(po_ready),
    .out_data(po_data)
  );

  // register bus
  wire cfg_hit = bus_req.addr[4:3] == `CFG_PAGE;
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (cfg_hit) begin
      rd_mux = cfg_ram[bus_req.addr[2:0]];
    end else begin
      case (bus_req.addr)
        `ADDR_ACC0: rd_mux = {8'h00, acc[0]};
        `ADDR_ACC1: rd_mux = {8'h00, acc[1]};
        `ADDR_OPR0: rd_mux = {8'h00, opr[0]};
        `ADDR_OPR1: rd_mux = {8'h00, opr[1]};
        `ADDR_QUEUE0: rd_mux = q_out_valid[0] ? {8'h00, q_head[0]} : 16'h0000;
        `ADDR_QUEUE1: rd_mux = q_out_valid[1] ? {8'h00, q_head[1]} : 16'h0000;
        `ADDR_OR_MASK: rd_mux = {8'h00, or_mask};
        `ADDR_CTL: rd_mux = {8'h00, ctl};
        `ADDR_CMP_MASK: rd_mux = cmp_mask;
        `ADDR_POLY: rd_mux = {8'h00, poly};
        `ADDR_STATUS: rd_mux = cond;
        `ADDR_OSEL_LO: rd_mux = osel[15:0];
        `ADDR_OSEL_HI: rd_mux = {8'h00, osel[23:16]};
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // routed condition outputs, each picks one of sixteen conditions
  logic [5:0] next_dp_out;
  for (genvar i = 0; i < 6; i++) begin : g_dpo
    assign next_dp_out[i] = cond[osel[i*4 +: 4]];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc <= {2{`REG_RST}};
      opr <= {2{`REG_RST}};
      or_mask <= `OR_MASK_RST;
      ctl <= `CTL_RST;
      poly <= `POLY_RST;
      cmp_mask <= `CMP_MASK_RST;
      osel <= `OSEL_RST;
      bus_rdata <= 16'h0000;
      bus_ack <= 1'b0;
      dp_out <= 6'h00;
    end else begin
      acc <= next_acc;
      opr <= next_opr;
      bus_rdata <= bus_req.rd ? rd_mux : 16'h0000;
      bus_ack <= bus_req.rd | bus_req.wr;
      dp_out <= next_dp_out;
      if (bus_req.wr) begin
        case (bus_req.addr)
          `ADDR_OR_MASK: or_mask <= bus_req.wdata[7:0];
          `ADDR_CTL: ctl <= bus_req.wdata[7:0];
          `ADDR_POLY: poly <= bus_req.wdata[7:0];
          `ADDR_CMP_MASK: cmp_mask <= bus_req.wdata;
          `ADDR_OSEL_LO: osel[15:0] <= bus_req.wdata;
          `ADDR_OSEL_HI: osel[23:16] <= bus_req.wdata[7:0];
          default: ;
        endcase
      end
    end
  end
  // configuration store holds its content across reset only by rewriting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 8; k++) begin
        cfg_ram[k] <= `CFG_RST;
      end
    end else if (bus_req.wr && cfg_hit) begin
      cfg_ram[bus_req.addr[2:0]] <= bus_req.wdata;
    end
  end
endmodule

// File: verification/cell_monitor.sv
/*
  Checker for the logic cell: bus answer timing, output buffer hold, outputs of logic array 0.
  Assumes it is bound to logic_cell and sees only its ports.
*/
module cell_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cell_pkg::bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic [1:0][11:0] pld_in,
  input wire cell_pkg::pld_cfg_t [1:0] pld_cfg,
  input wire logic [1:0][3:0] pld_out,
  input wire logic [7:0] po_data,
  input wire logic po_valid,
  input wire logic po_ready
);
  import cell_pkg::*;
  logic req;
  logic [3:0] sop0;
  // an empty product term reads 0, so unused terms never set an output
  function automatic logic [3:0] sop(input logic [11:0] x, input pld_cfg_t c);
    logic [7:0] t;
    for (int i = 0; i < 8; i++) begin
      t[i] = |(c.pt_true[i] | c.pt_comp[i]) &&
             &((~c.pt_true[i] | x) & (~c.pt_comp[i] | ~x));
    end
    for (int o = 0; o < 4; o++) begin
      sop[o] = |(c.or_sel[o] & t);
    end
  endfunction
  assign req = bus_req.wr || bus_req.rd;
  assign sop0 = sop(pld_in[0], pld_cfg[0]);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ack_after_req_a: assert property (req |=> bus_ack)
    else $error("bus ack missing");
  no_stray_ack_a: assert property (!req |=> !bus_ack)
    else $error("bus ack without request");
  idle_rdata_zero_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data without read");
  upper_byte_zero_a: assert property (
    bus_req.rd && bus_req.addr <= 5'h05 |=> bus_rdata[15:8] == 8'h00)
    else $error("upper byte of working register not zero");
  unmapped_read_a: assert property (
    bus_req.rd && bus_req.addr inside {[5'h0D:5'h0F], [5'h18:5'h1F]} |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  po_hold_a: assert property (po_valid && !po_ready |=> po_valid && $stable(po_data))
    else $error("output buffer head changed while stalled");
  pld_comb_a: assert property (
    (pld_out[0] & ~pld_cfg[0].reg_out) == (sop0 & ~pld_cfg[0].reg_out))
    else $error("combinational array output wrong");
  pld_reg_a: assert property (
    $past(nrst) |-> (pld_out[0] & pld_cfg[0].reg_out) == ($past(sop0) & pld_cfg[0].reg_out))
    else $error("registered array output wrong");
endmodule
bind logic_cell cell_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .pld_in(pld_in), .pld_cfg(pld_cfg),
  .pld_out(pld_out), .po_data(po_data), .po_valid(po_valid), .po_ready(po_ready));

// File: verification/po_sink.sv
/*
  Consumer of the output buffer on the routing side: stalls, takes promptly or slowly.
  Assumes sys_clk domain; mode 0 stall, 1 prompt, 2 every other cycle.
*/
module po_sink (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic po_valid,
  input wire logic [7:0] po_data,
  input wire logic [1:0] mode,
  output logic po_ready,
  output logic [7:0] got [0:7],
  output int n_got
);
  logic tick;
  assign po_ready = (mode == 2'h1) || (mode == 2'h2 && tick);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 1'b0;
      n_got <= 0;
    end else begin
      tick <= ~tick;
      if (po_valid && po_ready) begin
        got[n_got[2:0]] <= po_data;
        n_got <= n_got + 1;
      end
    end
  end
endmodule

// File: verification/tb_top.sv
/*
  Self-checking bench of the logic cell: registers, ALU, shifts, queues, output buffer.
  Assumes config word 0 is all hold, so the datapath idles with dp_in at 0.
*/
`include "cell_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cell_pkg::*;
  logic sys_clk, nrst, po_ready, bus_ack, po_valid;
  bus_req_t bus_req;
  logic [15:0] bus_rdata, rdat;
  logic [5:0] dp_in, dp_out;
  logic [1:0][11:0] pld_in;
  pld_cfg_t [1:0] pld_cfg;
  logic [1:0][3:0] pld_out;
  chain_up_t up_in, up_out;
  chain_down_t down_in, down_out;
  logic [7:0] po_data;
  logic [7:0] got [0:7];
  logic [1:0] mode;
  int n_got, failures, n_checks;
  logic_cell uut (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .dp_in(dp_in), .dp_out(dp_out), .up_in(up_in), .down_in(down_in),
    .up_out(up_out), .down_out(down_out), .pld_in(pld_in), .pld_cfg(pld_cfg),
    .pld_out(pld_out),
    .po_data(po_data), .po_valid(po_valid), .po_ready(po_ready));
  po_sink sink (.sys_clk(sys_clk), .nrst(nrst), .po_valid(po_valid), .po_data(po_data),
    .mode(mode), .po_ready(po_ready), .got(got), .n_got(n_got));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1 bus_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 bus_req = '0;
    rdat = bus_rdata;
    chk("bus_ack", 16'h0001, {15'h0, bus_ack});
  endtask
  // the bench plays the sequencer: it picks the word for each cycle
  task automatic run(input logic [2:0] w, input int n);
    @(posedge sys_clk);
    #1 dp_in = {3'h0, w};
    repeat (n) @(posedge sys_clk);
    #1 dp_in = 6'h00;
  endtask
  function automatic logic [15:0] cw(alu_func_t f, shift_op_t s, acc_wr_t a0, logic q, p);
    cfg_word_t c;
    c = '0;
    c.func = f;
    c.srcb = SRC_OPR0;
    c.shift = s;
    c.a0_sel = a0;
    c.q_strobe = q;
    c.po_push = p;
    return c;
  endfunction
  task automatic t_reset;
    bus(0, `ADDR_CTL, 16'h0);
    chk("ctl", 16'h0007, rdat);
    bus(0, `ADDR_CMP_MASK, 16'h0);
    chk("cmp_mask", 16'hFFFF, rdat);
    bus(0, `ADDR_ACC1, 16'h0);
    chk("acc1", 16'h0000, rdat);
    bus(1, 5'h0D, 16'hA5A5);
    bus(0, 5'h0D, 16'h0);
    chk("unmapped", 16'h0000, rdat);
  endtask
  task automatic t_alu;
    logic [7:0] a, b, e;
    a = 8'hC5;
    b = 8'h3A;
    for (int f = 0; f < 8; f++) begin
      bus(1, `ADDR_ACC0, {8'h00, a});
      bus(1, `ADDR_OPR0, {8'h00, b});
      bus(1, 5'h11, cw(alu_func_t'(f), SH_NONE, WR_ALU, 1'b0, 1'b0));
      run(3'h1, 1);
      bus(0, `ADDR_ACC0, 16'h0);
      case (f)
        0: e = a + 8'h01;
        1: e = a - 8'h01;
        2: e = a + b;
        3: e = a - b;
        4: e = a & b;
        5: e = a | b;
        6: e = a ^ b;
        default: e = a;
      endcase
      chk("alu", {8'h00, e}, rdat);
    end
  endtask
  task automatic t_shift;
    shift_op_t ops [0:3];
    logic [7:0] ex [0:3];
    ops = '{SH_LEFT, SH_RIGHT, SH_SWAP, SH_NONE};
    ex = '{8'h8A, 8'h62, 8'h5C, 8'hF5};
    for (int i = 0; i < 4; i++) begin
      bus(1, `ADDR_OR_MASK, (i == 3) ? 16'h0030 : 16'h0000);
      bus(1, `ADDR_ACC0, 16'h00C5);
      bus(1, 5'h11, cw(F_PASS, ops[i], WR_ALU, 1'b0, 1'b0));
      run(3'h1, 1);
      bus(0, `ADDR_ACC0, 16'h0);
      chk("shift", {8'h00, ex[i]}, rdat);
    end
    bus(1, `ADDR_OR_MASK, 16'h0000);
  endtask
  task automatic t_msb;
    bus(1, `ADDR_CTL, 16'h0003);
    bus(1, `ADDR_ACC0, 16'h002F);
    bus(1, 5'h11, cw(F_INC, SH_NONE, WR_ALU, 1'b0, 1'b0));
    run(3'h1, 1);
    bus(0, `ADDR_ACC0, 16'h0);
    // bits above the top bit take no part: only the carry lands just above it
    chk("narrow inc", 16'h0010, rdat);
    bus(1, `ADDR_CTL, 16'h0007);
  endtask
  task automatic t_queue;
    // fifth write meets a full queue and is dropped
    for (int i = 0; i < 5; i++) bus(1, `ADDR_QUEUE0, 16'h0010 + 16'(i));
    bus(0, `ADDR_STATUS, 16'h0);
    chk("queue full", 16'h0001, {15'h0, rdat[12]});
    bus(1, 5'h12, cw(F_PASS, SH_NONE, WR_HOLD, 1'b1, 1'b0));
    for (int i = 0; i < 4; i++) begin
      run(3'h2, 1);
      bus(0, `ADDR_OPR0, 16'h0);
      chk("queue head", 16'h0010 + 16'(i), rdat);
    end
    bus(0, `ADDR_STATUS, 16'h0);
    chk("queue empty", 16'h0001, {15'h0, rdat[11]});
  endtask
  task automatic t_po;
    mode = 2'h0;
    bus(1, `ADDR_ACC0, 16'h0000);
    bus(1, 5'h13, cw(F_INC, SH_NONE, WR_ALU, 1'b0, 1'b1));
    run(3'h3, 10);
    bus(0, `ADDR_ACC0, 16'h0);
    chk("stalled acc", 16'h0008, rdat);
    mode = 2'h2;
    for (int i = 0; i < 100 && n_got < 8; i++) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 8; i++) chk("po data", 16'(i + 1), {8'h00, got[i]});
    chk("po empty", 16'h0000, {15'h0, po_valid});
    mode = 2'h1;
  endtask
  task automatic t_cond;
    bus(1, `ADDR_OSEL_LO, 16'h0004);
    bus(1, `ADDR_ACC0, 16'h0000);
    bus(1, `ADDR_OPR0, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1 chk("dp_out", 16'h0001, {10'h0, dp_out});
    bus(1, `ADDR_ACC0, 16'h0001);
    repeat (2) @(posedge sys_clk);
    #1 chk("dp_out", 16'h003E, {10'h0, dp_out});
  endtask
  task automatic t_pld;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      #1 pld_in = {2{10'h0, 2'(i)}};
      @(posedge sys_clk);
      #1 chk("array comb", {15'h0, i == 1}, {15'h0, pld_out[1][0]});
      chk("array reg", {15'h0, i == 1}, {15'h0, pld_out[1][1]});
    end
  endtask
  task automatic t_qout;
    bus(1, `ADDR_CTL, 16'h000F);
    bus(1, `ADDR_ACC0, 16'h005A);
    bus(1, 5'h16, cw(F_PASS, SH_NONE, WR_HOLD, 1'b1, 1'b0));
    run(3'h6, 1);
    bus(0, `ADDR_QUEUE0, 16'h0);
    chk("queue out", 16'h005A, rdat);
    bus(0, `ADDR_STATUS, 16'h0);
    chk("queue drained", 16'h0001, {15'h0, rdat[11]});
  endtask
  task automatic t_chain;
    bus(1, `ADDR_CTL, 16'h0087);
    bus(1, `ADDR_ACC0, 16'h00F0);
    bus(1, `ADDR_OPR0, 16'h000F);
    bus(1, 5'h14, cw(F_ADD, SH_NONE, WR_ALU, 1'b0, 1'b0) | 16'h2000);
    up_in = '{carry: 1'b1, shl: 1'b0, eq: 1'b1};
    @(posedge sys_clk);
    #1 dp_in = 6'h04;
    #1 chk("carry out", 16'h0001, {15'h0, up_out.carry});
    @(posedge sys_clk);
    #1 dp_in = 6'h00;
    bus(0, `ADDR_ACC0, 16'h0);
    chk("chained add", 16'h0000, rdat);
    bus(1, `ADDR_CTL, 16'h0047);
    bus(1, `ADDR_POLY, 16'h0007);
    bus(1, `ADDR_ACC0, 16'h0080);
    chk("feedback", 16'h0001, {15'h0, down_out.fb});
    bus(1, 5'h15, cw(F_PASS, SH_NONE, WR_ALU, 1'b0, 1'b0));
    run(3'h5, 2);
    bus(0, `ADDR_ACC0, 16'h0);
    chk("crc step", 16'h000E, rdat);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // tests need some 300 cycles; a hundred times that marks a hang
  initial begin
    #120000;
    failures++;
    results();
  end
  initial begin
    nrst = 1'b0;
    bus_req = '0;
    dp_in = 6'h00;
    pld_in = '0;
    up_in = '0;
    down_in = '0;
    mode = 2'h1;
    failures = 0;
    n_checks = 0;
    pld_cfg = '0;
    for (int a = 0; a < 2; a++) begin
      pld_cfg[a].pt_true[0] = 12'h001;
      pld_cfg[a].pt_comp[0] = 12'h002;
      pld_cfg[a].or_sel[0] = 8'h01;
      pld_cfg[a].or_sel[1] = 8'h01;
      pld_cfg[a].reg_out = 4'h2;
    end
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    t_reset();
    t_alu();
    t_shift();
    t_msb();
    t_queue();
    t_po();
    t_cond();
    t_pld();
    t_qout();
    t_chain();
    results();
  end
endmodule
